// ---- design/adc_trim_pkg.sv ----
// Purpose: constants and types for the converter core trim register bank
// Assumes: classic wishbone, 32-bit data, one word per register index
// Notes: byte address of a register is four times its index
// Notes on behaviour
// [RULE1] core b single-mode input-b timing trim, 8 bits
// [RULE2] core a dual-mode input-a offset trim applied
// [RULE3] core a dual-mode input-b offset trim applied
// [RULE4] core a single-mode input-a offset trim applied
// [RULE5] core a single-mode input-b offset trim applied
// [RULE6] reset loads every trim from fuse values
// [RULE7] trims readable and replaceable by software
// [RULE8] mode, input, calibration select trims; reserved ignored
`default_nettype none
package adc_trim_pkg;

	// ----------------------------------------
	// register indices (byte address = index * 4)
	// ----------------------------------------
	localparam logic [9:0] idx_core_b_single_inb_timing_trim = 10'h31b;
	localparam logic [9:0] idx_core_a_dual_ina_offset_trim   = 10'h344;
	localparam logic [9:0] idx_core_a_dual_inb_offset_trim   = 10'h346;
	localparam logic [9:0] idx_core_a_single_ina_offset_trim = 10'h348;
	localparam logic [9:0] idx_core_a_single_inb_offset_trim = 10'h34a;
	localparam logic [9:0] idx_trim_control                  = 10'h300; // mode and enable
	localparam logic [9:0] idx_trim_status                   = 10'h301; // applied values
	localparam logic [9:0] offset_index_step                 = 10'h002; // spacing of offsets

	// ----------------------------------------
	// field layout
	// ----------------------------------------
	localparam int offset_width      = 12; // live offset bits, 15:12 reserved
	localparam int timing_width      = 8;
	localparam int ctrl_single_bit   = 0; // 1 = single-channel mode
	localparam int ctrl_inb_bit      = 1; // 1 = input b is sampled
	localparam int ctrl_fg_cal_bit   = 2; // 1 = foreground calibration enabled
	localparam int stat_a_off_lsb    = 0;
	localparam int stat_a_apply_bit  = 12;
	localparam int stat_b_tim_lsb    = 13;
	localparam int stat_b_apply_bit  = 21;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [2:0]  ctrl_reset  = 3'h0;
	localparam logic [31:0] rdata_reset = 32'h0;

	// bus handshake states, one-hot
	typedef enum logic [1:0] {
		bus_idle = 2'h1,
		bus_ack  = 2'h2
	} bus_state_type;

endpackage
`default_nettype wire

// ---- design/adc_core_trim_registers.sv ----
// Purpose: trim register bank steering core a offset and core b timing
// Assumes: fuse inputs come from fuse logic on clk_i, stable around reset
// Notes: one wait state; writes land on the edge that raises ack_o
`timescale 1ns/10ps
`default_nettype none
module adc_core_trim_registers (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [11:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// factory trims from fuse storage
	input  wire logic [7:0]  fuse_core_b_timing_i,
	input  wire logic [11:0] fuse_dual_ina_offset_i,
	input  wire logic [11:0] fuse_dual_inb_offset_i,
	input  wire logic [11:0] fuse_single_ina_offset_i,
	input  wire logic [11:0] fuse_single_inb_offset_i,
	// trims applied to the cores
	output logic      [11:0] core_a_offset_o,
	output logic             core_a_offset_apply_o,
	output logic      [7:0]  core_b_timing_o,
	output logic             core_b_timing_apply_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		adc_trim_pkg::bus_state_type bus;    // handshake phase
		logic                        ack;    // bus answer
		logic [31:0]                 rdata;  // read word
		logic [7:0]                  tim_b;  // core b timing trim
		logic [3:0][15:0]            off;    // {single,inb} indexed offsets
		logic [2:0]                  ctrl;   // mode, input, calibration
		logic [11:0]                 a_off;  // applied core a offset
		logic                        a_apply;
		logic [7:0]                  b_tim;  // applied core b timing
		logic                        b_apply;
	} state_type;

	state_type q;      // registered state
	state_type next_q; // next state

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
	                                        input logic [31:0] d,
	                                        input logic [3:0]  s);
		merge16 = old;
		if (s[0]) begin
			merge16[7:0] = d[7:0];
		end
		if (s[1]) begin
			merge16[15:8] = d[15:8];
		end
	endfunction

	logic [9:0] idx;        // word index of the access
	logic       single_sel; // single-channel mode selected
	logic       inb_sel;    // input b selected
	logic       fg_en;      // foreground calibration on

	assign idx        = adr_i[11:2];
	assign single_sel = q.ctrl[adc_trim_pkg::ctrl_single_bit];
	assign inb_sel    = q.ctrl[adc_trim_pkg::ctrl_inb_bit];
	assign fg_en      = q.ctrl[adc_trim_pkg::ctrl_fg_cal_bit];

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		logic        take;
		logic [9:0]  oidx;
		logic [31:0] rd;
		logic [1:0]  sel;
		take   = 1'b0;
		oidx   = 10'h0;
		rd     = 32'h0;
		sel    = 2'h0;
		next_q = q;
		// bus handshake: one wait state, ack held one cycle only
		case (q.bus)
			adc_trim_pkg::bus_idle: begin
				next_q.ack = 1'b0;
				if (cyc_i && stb_i) begin
					take       = 1'b1;
					next_q.bus = adc_trim_pkg::bus_ack;
					next_q.ack = 1'b1;
				end
			end
			adc_trim_pkg::bus_ack: begin
				// master releases the request at the ack edge
				next_q.bus = adc_trim_pkg::bus_idle;
				next_q.ack = 1'b0;
			end
			default: begin
				next_q.bus = adc_trim_pkg::bus_idle;
				next_q.ack = 1'b0;
			end
		endcase
		// register writes and read mux; unmapped reads as zero
		if (idx == adc_trim_pkg::idx_core_b_single_inb_timing_trim) begin
			rd[7:0] = q.tim_b; // RULE7
			if (take && we_i && sel_i[0]) begin
				next_q.tim_b = dat_i[7:0]; // RULE1
			end
		end
		if (idx == adc_trim_pkg::idx_trim_control) begin
			rd[2:0] = q.ctrl;
			if (take && we_i && sel_i[0]) begin
				next_q.ctrl = dat_i[2:0];
			end
		end
		if (idx == adc_trim_pkg::idx_trim_status) begin
			// read-only view of what the cores receive
			rd[adc_trim_pkg::stat_a_off_lsb +: 12] = q.a_off;
			rd[adc_trim_pkg::stat_a_apply_bit]     = q.a_apply;
			rd[adc_trim_pkg::stat_b_tim_lsb +: 8]  = q.b_tim;
			rd[adc_trim_pkg::stat_b_apply_bit]     = q.b_apply;
		end
		for (int i = 0; i < 4; i++) begin
			oidx = adc_trim_pkg::idx_core_a_dual_ina_offset_trim
			       + 10'(i) * adc_trim_pkg::offset_index_step;
			if (idx == oidx) begin
				rd[15:0] = q.off[i]; // RULE7
				if (take && we_i) begin
					// reserved bits stored as written, never applied
					next_q.off[i] = merge16(q.off[i], dat_i, sel_i); // RULE2 RULE3 RULE4 RULE5
				end
			end
		end
		if (take) begin
			next_q.rdata = rd;
		end
		// trim steering from mode, input and calibration enable
		sel = {single_sel, inb_sel};
		if (fg_en) begin
			next_q.a_off   = q.off[sel][adc_trim_pkg::offset_width-1:0]; // RULE2 RULE3 RULE4 RULE5 RULE8
			next_q.a_apply = 1'b1;
		end else begin
			next_q.a_off   = 12'h0; // RULE8
			next_q.a_apply = 1'b0;
		end
		// core b timing trim used only for single mode sampling input b
		if (fg_en && single_sel && inb_sel) begin
			next_q.b_tim   = q.tim_b; // RULE1
			next_q.b_apply = 1'b1;
		end else begin
			next_q.b_tim   = 8'h0;
			next_q.b_apply = 1'b0;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// factory trims rather than zero; reset is synchronous
			q.bus     <= adc_trim_pkg::bus_idle;
			q.ack     <= 1'b0;
			q.rdata   <= adc_trim_pkg::rdata_reset;
			q.tim_b   <= fuse_core_b_timing_i; // RULE6
			q.off[0]  <= {4'h0, fuse_dual_ina_offset_i}; // RULE6
			q.off[1]  <= {4'h0, fuse_dual_inb_offset_i};
			q.off[2]  <= {4'h0, fuse_single_ina_offset_i};
			q.off[3]  <= {4'h0, fuse_single_inb_offset_i};
			q.ctrl    <= adc_trim_pkg::ctrl_reset;
			q.a_off   <= 12'h0;
			q.a_apply <= 1'b0;
			q.b_tim   <= 8'h0;
			q.b_apply <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

	// outputs straight from flops
	assign dat_o                 = q.rdata;
	assign ack_o                 = q.ack;
	assign core_a_offset_o       = q.a_off;
	assign core_a_offset_apply_o = q.a_apply;
	assign core_b_timing_o       = q.b_tim;
	assign core_b_timing_apply_o = q.b_apply;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_after_req: assert property ( // RULE7
		(q.bus == adc_trim_pkg::bus_idle) && cyc_i && stb_i |=> ack_o ##1 !ack_o)
		else $error("ack not given for one cycle after request");
	a_timing_write_back: assert property ( // RULE7
		(q.bus == adc_trim_pkg::bus_idle) && cyc_i && stb_i && we_i && sel_i[0]
		&& idx == adc_trim_pkg::idx_core_b_single_inb_timing_trim
		|=> q.tim_b == $past(dat_i[7:0]))
		else $error("timing trim write lost");
	a_timing_b_single: assert property ( // RULE1
		fg_en && single_sel && inb_sel |=> core_b_timing_apply_o
		&& core_b_timing_o == $past(q.tim_b))
		else $error("core b timing trim not applied");
	a_offset_dual_ina: assert property ( // RULE2
		fg_en && !single_sel && !inb_sel |=> core_a_offset_o == $past(q.off[0][11:0]))
		else $error("dual input a offset not applied");
	a_offset_dual_inb: assert property ( // RULE3
		fg_en && !single_sel && inb_sel |=> core_a_offset_o == $past(q.off[1][11:0]))
		else $error("dual input b offset not applied");
	a_offset_single_ina: assert property ( // RULE4
		fg_en && single_sel && !inb_sel |=> core_a_offset_o == $past(q.off[2][11:0]))
		else $error("single input a offset not applied");
	a_offset_single_inb: assert property ( // RULE5
		fg_en && single_sel && inb_sel |=> core_a_offset_o == $past(q.off[3][11:0]))
		else $error("single input b offset not applied");
	a_fuse_reset_load: assert property ( // RULE6
		$past(rst_i) |-> q.tim_b == $past(fuse_core_b_timing_i)
		&& q.off[3][11:0] == $past(fuse_single_inb_offset_i))
		else $error("fuse trims not loaded at reset");
	a_cal_off_idle: assert property ( // RULE8
		!fg_en |=> !core_a_offset_apply_o && core_a_offset_o == 12'h0
		&& !core_b_timing_apply_o)
		else $error("trims applied without calibration");

	c_write_timing: cover property (
		ack_o && $past(we_i) && $past(idx) == adc_trim_pkg::idx_core_b_single_inb_timing_trim);
	c_read_offset: cover property (
		ack_o && !$past(we_i) && $past(idx) == adc_trim_pkg::idx_core_a_dual_inb_offset_trim);
	c_single_inb_cal: cover property (core_b_timing_apply_o && core_a_offset_apply_o);

endmodule
`default_nettype wire

// ---- tb/adc_core_trim_registers_tb.sv ----
// Purpose: self-checking bench for the trim register bank
// Assumes: one wait state bus, fuse values held stable through reset
// Notes: every trim reaches the cores only once fg calibration is enabled
`timescale 1ns/10ps
`default_nettype none
module adc_core_trim_registers_tb;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i  = 1'b0;
	logic [11:0] adr_i = 12'h0;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic [11:0] fuse_off [4]  = '{12'h123, 12'h456, 12'h789, 12'habc}; // factory offsets
	logic [7:0]  fuse_tim      = 8'h5a;                                 // factory timing
	logic [11:0] core_a_offset_o;
	logic        core_a_offset_apply_o;
	logic [7:0]  core_b_timing_o;
	logic        core_b_timing_apply_o;
	logic [31:0] q;                                                     // last read data
	logic [3:0]  lanes         = 4'h3;                                  // byte lanes of next access
	int          mismatches = 0;
	int          n_compared = 0;
	always #25 clk_i = ~clk_i; // 20 mhz
	adc_core_trim_registers uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.fuse_core_b_timing_i(fuse_tim), .fuse_dual_ina_offset_i(fuse_off[0]),
		.fuse_dual_inb_offset_i(fuse_off[1]), .fuse_single_ina_offset_i(fuse_off[2]),
		.fuse_single_inb_offset_i(fuse_off[3]), .core_a_offset_o(core_a_offset_o),
		.core_a_offset_apply_o(core_a_offset_apply_o), .core_b_timing_o(core_b_timing_o),
		.core_b_timing_apply_o(core_b_timing_apply_o));
	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	// one classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= {idx, 2'h0};
		dat_i <= d;
		sel_i <= lanes;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		if (n >= 20) begin // lost answer counts as a mismatch
			mismatches++;
			$display("MISMATCH ack exp 1 got %b", ack_o);
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask
	// cores update one edge after the register edge; wait two to be safe
	task automatic chk_cores(input logic [11:0] off, input logic aon, input logic [7:0] tim,
		input logic bon);
		repeat (2) @(posedge clk_i);
		chk("a_offset", {20'h0, off}, {20'h0, core_a_offset_o});
		chk("a_apply", {31'h0, aon}, {31'h0, core_a_offset_apply_o});
		chk("b_timing", {24'h0, tim}, {24'h0, core_b_timing_o});
		chk("b_apply", {31'h0, bon}, {31'h0, core_b_timing_apply_o});
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ----------------------------------------
	// watchdog and main sequence
	// ----------------------------------------
	initial begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_cores(12'h0, 1'b0, 8'h0, 1'b0);
		wb(1'b0, adc_trim_pkg::idx_core_b_single_inb_timing_trim, 32'h0);
		chk("tim_reset", {24'h0, fuse_tim}, q);
		for (int i = 0; i < 4; i++) begin // fuse defaults, then reserved bits kept
			wb(1'b0, adc_trim_pkg::idx_core_a_dual_ina_offset_trim + 10'(2 * i), 32'h0);
			chk("off_reset", {20'h0, fuse_off[i]}, q);
			wb(1'b1, adc_trim_pkg::idx_core_a_dual_ina_offset_trim + 10'(2 * i),
				32'hf0f1 + 32'(i));
			wb(1'b0, adc_trim_pkg::idx_core_a_dual_ina_offset_trim + 10'(2 * i), 32'h0);
			chk("off_rw", 32'hf0f1 + 32'(i), q);
		end
		$display("test reset and readback done");
		wb(1'b1, adc_trim_pkg::idx_core_b_single_inb_timing_trim, 32'h0000_00c3);
		wb(1'b0, adc_trim_pkg::idx_core_b_single_inb_timing_trim, 32'h0);
		chk("tim_rw", 32'hc3, q);
		for (int i = 0; i < 4; i++) begin // each mode and input with calibration on
			wb(1'b1, adc_trim_pkg::idx_trim_control, {29'h0, 1'b1, 1'(i), 1'(i >> 1)});
			chk_cores(12'h0f1 + 12'(i), 1'b1, (i == 3) ? 8'hc3 : 8'h0, i == 3);
			// status mirrors what the cores receive
			wb(1'b0, adc_trim_pkg::idx_trim_status, 32'h0);
			chk("status", {10'h0, i == 3, 8'hc3 & {8{i == 3}}, 1'b1, 12'h0f1 + 12'(i)}, q);
		end
		wb(1'b1, adc_trim_pkg::idx_trim_control, 32'h3);
		chk_cores(12'h0, 1'b0, 8'h0, 1'b0);
		$display("test mode steering done");
		wb(1'b1, 10'h3ff, 32'hffff_ffff);
		wb(1'b0, 10'h3ff, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("test unmapped done");
		// byte lanes: offset low byte only, timing write on lane 1 is dropped
		lanes = 4'h1;
		wb(1'b1, adc_trim_pkg::idx_core_a_dual_ina_offset_trim, 32'h0000_1234);
		lanes = 4'h2;
		wb(1'b1, adc_trim_pkg::idx_core_b_single_inb_timing_trim, 32'h0000_7777);
		lanes = 4'h3;
		wb(1'b0, adc_trim_pkg::idx_core_a_dual_ina_offset_trim, 32'h0);
		chk("off_lane", 32'hf034, q);
		wb(1'b0, adc_trim_pkg::idx_core_b_single_inb_timing_trim, 32'h0);
		chk("tim_lane", 32'hc3, q);
		wb(1'b0, adc_trim_pkg::idx_trim_control, 32'h0);
		chk("ctrl_rw", 32'h3, q);
		$display("test byte lanes done");
		// second reset mid-run with a new fuse value: trims reload from fuses
		@(posedge clk_i);
		fuse_tim <= 8'ha5;
		rst_i    <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, adc_trim_pkg::idx_core_b_single_inb_timing_trim, 32'h0);
		chk("tim_reload", 32'ha5, q);
		wb(1'b0, adc_trim_pkg::idx_core_a_dual_ina_offset_trim, 32'h0);
		chk("off_reload", {20'h0, fuse_off[0]}, q);
		chk_cores(12'h0, 1'b0, 8'h0, 1'b0);
		$display("test reset reload done");
		conclude();
	end
endmodule
`default_nettype wire
